// ==== verilog/host_port_params.svh ====
// Constants for the host port mode and interrupt block
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

// Clock rate and strap settle time after reset release
`define HPM_CLK_PERIOD_NS 100
`define HPM_SETTLE_CYCLES 2'h3
`define HPM_SETTLE_W 2

// Report queue depth counter
`define HPM_PEND_W 8
`define HPM_PEND_MAX 8'hFF
`define HPM_PEND_ZERO 8'h00

// General purpose pins and the two sync alternates
`define HPM_GPIO_COUNT 5
`define HPM_HSYNC_PIN 1
`define HPM_VSYNC_PIN 2
`define HPM_GPIO_IDLE_OEN 5'h1F

// Serial byte layout
`define HPM_BYTE_W 8
`define HPM_LAST_BIT 3'h7

// Mode encoding of the latched strap
`define HPM_MODE_I2C 1'h0
`define HPM_MODE_SPI 1'h1

// Synchroniser lane positions
`define HPM_SY_W 10
`define HPM_SY_STRAP 0
`define HPM_SY_SDA 1
`define HPM_SY_SCL 2
`define HPM_SY_ADDR 3
`define HPM_SY_RXT 4
`define HPM_SY_GPIO 5

`endif

// ==== verilog/host_port_pkg.sv ====
// Types for the host port mode and interrupt block
`default_nettype none
package host_port_pkg;

    typedef enum logic [0:0] {
        PH_SETTLE,
        PH_RUN
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic [1:0] settleCnt;
        logic spiMode;
        logic [7:0] pending;
        logic irqDrive;
        logic rxSeen;
        logic [7:0] rxByte;
        logic rxValid;
        logic [7:0] txHold;
        logic [4:0] gpioOut;
        logic [4:0] gpioOeN;
    } core_state_t;

    typedef struct packed {
        logic [7:0] shift;
        logic [2:0] bitCnt;
    } link_frame_t;

    typedef struct packed {
        logic [7:0] rxWord;
        logic rxToggle;
    } link_keep_t;

endpackage
`default_nettype wire

// ==== verilog/sync_two_ff.sv ====
// Two flip-flop synchroniser for a group of independent levels
`timescale 1ns/100ps
`default_nettype none
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic master_reset_n,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);

    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge master_reset_n) begin
        if (!master_reset_n) begin
            stage1 <= '0;
            synced <= '0;
        end else begin
            stage1 <= async;
            synced <= stage1;
        end
    end

endmodule // sync_two_ff
`default_nettype wire

// ==== verilog/spi_link.sv ====
// Serial shifter running on the host serial clock
`timescale 1ns/100ps
`default_nettype none
`include "host_port_params.svh"
module spi_link
    import host_port_pkg::*;
(
    input wire logic spiClk,
    input wire logic master_reset_n,
    input wire logic spiMode,
    input wire logic slaveSelN,
    input wire logic mosi,
    input wire logic [7:0] txByte,
    output logic misoBit,
    output logic [7:0] rxByte,
    output logic rxToggle
);

    link_frame_t frame;
    link_frame_t next_frame;
    link_keep_t keep;
    link_keep_t next_keep;
    logic frameClear;

    // The serial clock stops between frames, so deselect ends the frame
    assign frameClear = slaveSelN | ~spiMode | ~master_reset_n;

    always_comb begin
        next_frame = frame;
        next_keep = keep;
        next_frame.shift = {frame.shift[6:0], mosi};
        next_frame.bitCnt = frame.bitCnt + 3'h1;
        if (frame.bitCnt == `HPM_LAST_BIT) begin
            next_keep.rxWord = {frame.shift[6:0], mosi};
            next_keep.rxToggle = ~keep.rxToggle;
        end
    end

    // Frame part clears on deselect; the toggle must survive it
    always_ff @(posedge spiClk or posedge frameClear) begin
        if (frameClear) begin
            frame <= '0;
        end else begin
            frame <= next_frame;
        end
    end

    always_ff @(posedge spiClk or negedge master_reset_n) begin
        if (!master_reset_n) begin
            keep <= '0;
        end else begin
            keep <= next_keep;
        end
    end

    // Reply byte goes out MSB first and is held stable by the core
    assign misoBit = txByte[~frame.bitCnt];
    assign rxByte = keep.rxWord;
    assign rxToggle = keep.rxToggle;

endmodule // spi_link
`default_nettype wire

// ==== verilog/host_port_mode_and_irq.sv ====
// Host pin mode latch, pin sharing and report interrupt
`timescale 1ns/100ps
`default_nettype none
`include "host_port_params.svh"
module host_port_mode_and_irq
    import host_port_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic master_reset_n,
    input wire logic spiClk,
    input wire logic host_report_irq_n_in,
    output logic host_report_irq_n_out,
    output logic host_report_irq_n_oe_n,
    input wire logic target_serial_data_in,
    output logic target_serial_data_out,
    output logic target_serial_data_oe_n,
    input wire logic target_serial_clock_in,
    output logic target_serial_clock_out,
    output logic target_serial_clock_oe_n,
    input wire logic target_address_select,
    input wire logic interface_mode_strap_n_in,
    output logic interface_mode_strap_n_out,
    output logic interface_mode_strap_n_oe_n,
    input wire logic [4:0] gpioPinIn,
    output logic [4:0] gpioPinOut,
    output logic [4:0] gpioPinOeN,
    input wire logic reportQueued,
    input wire logic reportConsumed,
    input wire logic i2cDataPullLow,
    input wire logic i2cClockHold,
    input wire logic [4:0] gpioDriveEnable,
    input wire logic [4:0] gpioDriveValue,
    input wire logic hsyncSelect,
    input wire logic syncSelect,
    input wire logic [7:0] spiTxByte,
    output logic modeLocked,
    output logic spiMode,
    output logic i2cAddressSelect,
    output logic i2cDataLevel,
    output logic i2cClockLevel,
    output logic spiSelected,
    output logic [7:0] spiRxByte,
    output logic spiRxValid,
    output logic [7:0] pendingReports,
    output logic [4:0] gpioLevel,
    output logic hsyncLevel,
    output logic external_sync_input
);

    core_state_t st;
    core_state_t next_st;
    logic [`HPM_SY_W-1:0] syncIn;
    logic [`HPM_SY_W-1:0] syncOut;
    logic [4:0] gpioSynced;
    logic linkMiso;
    logic [7:0] linkRxByte;
    logic linkRxToggle;
    logic running;
    logic spiRun;
    logic i2cRun;
    logic [4:0] gpioDrive;

    // General pins rest released on their pull-ups while in reset
    localparam core_state_t RESET_STATE = core_state_t'({
        {($bits(core_state_t) - `HPM_GPIO_COUNT){1'b0}},
        `HPM_GPIO_IDLE_OEN});

    // A sync alternate forces its pin to stay an input
    function automatic logic syncClaims(input int idx, input logic hSel,
                                        input logic vSel);
        syncClaims = ((idx == `HPM_HSYNC_PIN) && hSel) ||
                     ((idx == `HPM_VSYNC_PIN) && vSel);
    endfunction

    // Every pin level passes two flops before the core looks at it
    assign syncIn[`HPM_SY_STRAP] = interface_mode_strap_n_in;
    assign syncIn[`HPM_SY_SDA] = target_serial_data_in;
    assign syncIn[`HPM_SY_SCL] = target_serial_clock_in;
    assign syncIn[`HPM_SY_ADDR] = target_address_select;
    assign syncIn[`HPM_SY_RXT] = linkRxToggle;
    assign syncIn[`HPM_SY_W-1:`HPM_SY_GPIO] = gpioPinIn;

    sync_two_ff #(
        .WIDTH(`HPM_SY_W)
    ) u_sync (
        .clk(clk),
        .master_reset_n(master_reset_n),
        .async(syncIn),
        .synced(syncOut)
    );

    assign gpioSynced = syncOut[`HPM_SY_W-1:`HPM_SY_GPIO];

    // Link side shifter; pin 1 carries its clock in SPI mode
    spi_link u_link (
        .spiClk(spiClk),
        .master_reset_n(master_reset_n),
        .spiMode(spiRun),
        .slaveSelN(target_serial_clock_in),
        .mosi(target_address_select),
        .txByte(st.txHold),
        .misoBit(linkMiso),
        .rxByte(linkRxByte),
        .rxToggle(linkRxToggle)
    );

    assign running = (st.phase == PH_RUN);
    assign spiRun = running & st.spiMode;
    assign i2cRun = running & ~st.spiMode;

    // General pin drive decode, one copy per pin
    genvar g;
    generate
        for (g = 0; g < `HPM_GPIO_COUNT; g++) begin : gen_gpio
            assign gpioDrive[g] = gpioDriveEnable[g] &
                ~syncClaims(g, hsyncSelect, syncSelect);
        end
    endgenerate

    always_comb begin
        next_st = st;
        next_st.rxValid = 1'h0;

        // Hold off until the strap has crossed both synchroniser flops
        case (st.phase)
            PH_SETTLE: begin
                if (st.settleCnt == `HPM_SETTLE_CYCLES) begin
                    next_st.phase = PH_RUN;
                    // Low selects I2C, high selects SPI
                    next_st.spiMode = syncOut[`HPM_SY_STRAP];
                end else begin
                    next_st.settleCnt = st.settleCnt + 2'h1;
                end
            end
            PH_RUN: begin
                // Mode is never rewritten here; only reset reopens it
                next_st.spiMode = st.spiMode;
            end
            default: begin
                next_st.phase = PH_SETTLE;
            end
        endcase

        // Queue and consume in one cycle cancel, so no report is lost
        if (reportQueued && !reportConsumed) begin
            if (st.pending != `HPM_PEND_MAX) begin
                next_st.pending = st.pending + 8'h01;
            end
        end else if (reportConsumed && !reportQueued) begin
            if (st.pending != `HPM_PEND_ZERO) begin
                next_st.pending = st.pending - 8'h01;
            end
        end
        // Level output, so reports left after a read keep it low
        next_st.irqDrive = (next_st.pending != `HPM_PEND_ZERO);

        // Completed byte from the link: toggle crossing gives one pulse
        next_st.rxSeen = syncOut[`HPM_SY_RXT];
        if (spiRun && (syncOut[`HPM_SY_RXT] != st.rxSeen)) begin
            next_st.rxByte = linkRxByte;
            next_st.rxValid = 1'h1;
        end

        // Reply byte changes only while deselected, so the link sees it
        // stable for a whole frame; a load racing a select is a hazard
        if (syncOut[`HPM_SY_SCL]) begin
            next_st.txHold = spiTxByte;
        end

        next_st.gpioOut = gpioDriveValue;
        next_st.gpioOeN = ~gpioDrive;
    end

    // Master reset acts at once; system reset waits for the clock
    always_ff @(posedge clk or negedge master_reset_n) begin
        if (!master_reset_n) begin
            st <= RESET_STATE;
        end else if (!rst_n) begin
            st <= RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    // Open drain interrupt; released pin rests on the pull-up
    assign host_report_irq_n_out = 1'h0;
    assign host_report_irq_n_oe_n = ~st.irqDrive;

    // Pin 1: open drain data in I2C mode, clock input in SPI mode
    assign target_serial_data_out = 1'h0;
    assign target_serial_data_oe_n = ~(i2cRun & i2cDataPullLow);

    // Pin 2: clock may be held low in I2C mode, select input in SPI
    assign target_serial_clock_out = 1'h0;
    assign target_serial_clock_oe_n = ~(i2cRun & i2cClockHold);

    // Strap pin turns into the reply output once SPI is chosen
    assign interface_mode_strap_n_out = spiRun & linkMiso;
    assign interface_mode_strap_n_oe_n = ~spiRun;

    assign gpioPinOut = st.gpioOut;
    assign gpioPinOeN = st.gpioOeN;

    assign modeLocked = running;
    assign spiMode = spiRun;
    // Address select meaning applies only in I2C mode
    assign i2cAddressSelect = i2cRun & syncOut[`HPM_SY_ADDR];
    assign i2cDataLevel = syncOut[`HPM_SY_SDA];
    assign i2cClockLevel = syncOut[`HPM_SY_SCL];
    // Select is active low on the pin
    assign spiSelected = spiRun & ~syncOut[`HPM_SY_SCL];
    assign spiRxByte = st.rxByte;
    assign spiRxValid = st.rxValid;
    assign pendingReports = st.pending;
    assign gpioLevel = gpioSynced;
    assign hsyncLevel = hsyncSelect & gpioSynced[`HPM_HSYNC_PIN];
    assign external_sync_input = syncSelect & gpioSynced[`HPM_VSYNC_PIN];

endmodule // host_port_mode_and_irq
`default_nettype wire

// ==== bench/host_port_sva.sv ====
// Checker for report interrupt, mode latch and shared pin use
`timescale 1ns/100ps
`default_nettype none
module host_port_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic master_reset_n,
    input wire logic reportQueued,
    input wire logic reportConsumed,
    input wire logic [7:0] pendingReports,
    input wire logic host_report_irq_n_oe_n,
    input wire logic modeLocked,
    input wire logic spiMode,
    input wire logic interface_mode_strap_n_oe_n,
    input wire logic target_serial_data_oe_n,
    input wire logic i2cDataPullLow
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n || !master_reset_n);
    irq_low_a: assert property (
        pendingReports != 8'h00 |-> !host_report_irq_n_oe_n)
        else $error("irq not driven");
    irq_release_a: assert property (
        pendingReports == 8'h00 |-> host_report_irq_n_oe_n)
        else $error("irq not released");
    queue_count_a: assert property (
        reportQueued && !reportConsumed && pendingReports != 8'hFF
        |=> pendingReports == $past(pendingReports) + 8'h01)
        else $error("queue not counted");
    consume_count_a: assert property (
        reportConsumed && !reportQueued && pendingReports != 8'h00
        |=> pendingReports == $past(pendingReports) - 8'h01)
        else $error("read not counted");
    mode_lock_a: assert property (
        $rose(rst_n) |-> ##[1:6] modeLocked)
        else $error("mode not latched");
    mode_hold_a: assert property (
        modeLocked |=> modeLocked && $stable(spiMode))
        else $error("mode changed");
    miso_drive_a: assert property (
        modeLocked |-> interface_mode_strap_n_oe_n == !spiMode)
        else $error("strap pin direction wrong");
    sda_drive_a: assert property (
        modeLocked |-> target_serial_data_oe_n
        == (spiMode || !i2cDataPullLow))
        else $error("data pin drive wrong");
    cover property (reportQueued && pendingReports == 8'h02);
    cover property (reportConsumed && pendingReports == 8'h01);
    cover property ($rose(modeLocked) && spiMode);
endmodule // host_port_sva
bind host_port_mode_and_irq host_port_sva host_port_sva_i (.clk, .rst_n,
    .master_reset_n, .reportQueued, .reportConsumed, .pendingReports,
    .host_report_irq_n_oe_n, .modeLocked, .spiMode,
    .interface_mode_strap_n_oe_n, .target_serial_data_oe_n,
    .i2cDataPullLow);
`default_nettype wire

// ==== bench/spi_host_model.sv ====
// Host-side SPI master model for the shared pins
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
    output logic sck = 1'b0,
    output logic selN = 1'b1,
    output logic mosi = 1'b1,
    input wire logic miso
);
    // Clock stands low between frames; idle data shows the inverse
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        selN = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #40;
            rx[i] = miso;
            sck = 1'b1;
            #40;
            sck = 1'b0;
        end
        #40;
        selN = 1'b1;
        mosi = ~mosi;
    endtask
endmodule // spi_host_model
`default_nettype wire

// ==== bench/host_port_mode_and_irq_tb.sv ====
// Self-checking bench for host port mode and report interrupt
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; \
    if ((got) !== (ex)) begin n_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module host_port_mode_and_irq_tb;
    int n_errors = 0;
    int n_checks = 0;
    logic clk, rst_n = 1'b0, master_reset_n = 1'b1, strapHigh = 1'b0;
    logic reportQueued = 1'b0, reportConsumed = 1'b0, addrSel = 1'b1;
    logic i2cDataPullLow = 1'b0, i2cClockHold = 1'b0;
    logic hsyncSelect = 1'b0, syncSelect = 1'b0;
    logic [4:0] gpioDriveEnable = 5'h00, gpioDriveValue = 5'h00;
    logic [4:0] gpioExt = 5'h1F, gpioPinOut, gpioPinOeN, gpioLevel;
    logic [7:0] spiTxByte = 8'h00, spiRxByte, pendingReports;
    logic host_report_irq_n_out, host_report_irq_n_oe_n;
    logic target_serial_data_out, target_serial_data_oe_n;
    logic target_serial_clock_out, target_serial_clock_oe_n;
    logic interface_mode_strap_n_out, interface_mode_strap_n_oe_n;
    logic modeLocked, spiMode, i2cAddressSelect, i2cDataLevel;
    logic i2cClockLevel, spiSelected, spiRxValid, hsyncLevel;
    logic external_sync_input, sck, selN, mosi;
    // Pull-ups hold the released interrupt pin, and the two I2C pins outside SPI mode, high
    wire logic host_report_irq_n_in = host_report_irq_n_oe_n ? 1'b1
        : host_report_irq_n_out;
    wire logic target_serial_data_in = !target_serial_data_oe_n
        ? target_serial_data_out : (spiMode ? sck : 1'b1);
    wire logic spiClk = target_serial_data_in;
    wire logic target_serial_clock_in = !target_serial_clock_oe_n
        ? target_serial_clock_out : (spiMode ? selN : 1'b1);
    wire logic target_address_select = spiMode ? mosi : addrSel;
    wire logic interface_mode_strap_n_in = !interface_mode_strap_n_oe_n
        ? interface_mode_strap_n_out : strapHigh;
    wire logic [4:0] gpioPinIn = (~gpioPinOeN & gpioPinOut)
        | (gpioPinOeN & gpioExt);
    host_port_mode_and_irq host_port_mode_and_irq_i (.clk, .rst_n,
        .master_reset_n, .spiClk, .host_report_irq_n_in,
        .host_report_irq_n_out, .host_report_irq_n_oe_n,
        .target_serial_data_in, .target_serial_data_out,
        .target_serial_data_oe_n, .target_serial_clock_in,
        .target_serial_clock_out, .target_serial_clock_oe_n,
        .target_address_select, .interface_mode_strap_n_in,
        .interface_mode_strap_n_out, .interface_mode_strap_n_oe_n,
        .gpioPinIn, .gpioPinOut, .gpioPinOeN, .reportQueued,
        .reportConsumed, .i2cDataPullLow, .i2cClockHold,
        .gpioDriveEnable, .gpioDriveValue, .hsyncSelect, .syncSelect,
        .spiTxByte, .modeLocked, .spiMode, .i2cAddressSelect,
        .i2cDataLevel, .i2cClockLevel, .spiSelected, .spiRxByte,
        .spiRxValid, .pendingReports, .gpioLevel, .hsyncLevel,
        .external_sync_input);
    spi_host_model spi_host_model_i (.sck, .selN, .mosi,
        .miso(interface_mode_strap_n_in));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Bounded wait: v low for the mode latch, v high for a byte
    task automatic wait_hi(input bit v);
        int k;
        for (k = 0; k < 30; k++) begin
            @(negedge clk);
            if ((v ? spiRxValid : modeLocked) === 1'b1) break;
        end
        if (k == 30) begin
            n_errors++;
            $display("[FAIL] wait exp 1 got 0");
            summarize();
        end
    endtask
    task automatic do_reset(input logic strap);
        strapHigh = strap;
        rst_n = 1'b0;
        cyc(3);
        rst_n = 1'b1;
        wait_hi(1'b0);
        `CHK("mode", strap, spiMode)
        `CHK("strapOeN", ~strap, interface_mode_strap_n_oe_n)
    endtask
    // Queue and consume overlap once, then read past empty
    task automatic t_reports;
        reportQueued = 1'b1;
        cyc(3);
        reportConsumed = 1'b1;
        cyc(1);
        reportQueued = 1'b0;
        `CHK("pend3", 8'h03, pendingReports)
        `CHK("irqPin", 1'b0, host_report_irq_n_in)
        cyc(1);
        `CHK("irqHeld", 1'b0, host_report_irq_n_in)
        cyc(3);
        reportConsumed = 1'b0;
        `CHK("pend0", 8'h00, pendingReports)
        `CHK("irqFree", 1'b1, host_report_irq_n_in)
    endtask
    task automatic t_i2c;
        for (int a = 0; a < 2; a++) begin
            addrSel = a[0];
            cyc(3);
            `CHK("addrSel", a[0], i2cAddressSelect)
        end
        i2cDataPullLow = 1'b1;
        i2cClockHold = 1'b1;
        cyc(3);
        `CHK("sdaLevel", 1'b0, i2cDataLevel)
        `CHK("sclLevel", 1'b0, i2cClockLevel)
        // A low clock line in I2C mode must not look like a select
        `CHK("spiSelI2c", 1'b0, spiSelected)
        i2cDataPullLow = 1'b0;
        i2cClockHold = 1'b0;
        cyc(3);
        `CHK("sclHigh", 1'b1, i2cClockLevel)
    endtask
    task automatic t_gpio;
        gpioExt = 5'h0A;
        cyc(3);
        `CHK("gpioIn", 5'h0A, gpioLevel)
        gpioDriveEnable = 5'h11;
        gpioDriveValue = 5'h01;
        cyc(3);
        `CHK("gpioOut", 5'h0B, gpioLevel)
        gpioDriveEnable = 5'h1F;
        gpioDriveValue = 5'h00;
        gpioExt = 5'h06;
        hsyncSelect = 1'b1;
        syncSelect = 1'b1;
        cyc(3);
        `CHK("hsync", 1'b1, hsyncLevel)
        `CHK("external_sync_input", 1'b1, external_sync_input)
        `CHK("gpioSync", 5'h06, gpioLevel)
        strapHigh = 1'b1;
        cyc(3);
        `CHK("modeHeld", 1'b0, spiMode)
    endtask
    task automatic t_spi;
        logic [7:0] rx;
        i2cDataPullLow = 1'b1;
        for (int b = 0; b < 2; b++) begin
            spiTxByte = b ? 8'hC3 : 8'h3C;
            cyc(1);
            #13;
            // Select is seen mid-frame, well before the host lets go
            fork
                spi_host_model_i.xfer(b ? 8'h5A : 8'hA5, rx);
                begin
                    cyc(4);
                    `CHK("spiSel", 1'b1, spiSelected)
                end
            join
            `CHK("miso", spiTxByte, rx)
            wait_hi(1'b1);
            `CHK("mosi", b ? 8'h5A : 8'hA5, spiRxByte)
        end
        i2cDataPullLow = 1'b0;
    endtask
    // Async reset lands mid-cycle, away from any clock edge
    task automatic t_master_reset;
        reportQueued = 1'b1;
        cyc(1);
        reportQueued = 1'b0;
        #20 master_reset_n = 1'b0;
        #10;
        `CHK("pendAsync", 8'h00, pendingReports)
        `CHK("irqAsync", 1'b1, host_report_irq_n_in)
        // General pins must not fight their pull-ups while in reset
        `CHK("gpioRst", 5'h1F, gpioPinOeN)
        @(negedge clk);
        master_reset_n = 1'b1;
        wait_hi(1'b0);
        `CHK("relatch", 1'b1, spiMode)
    endtask
    initial begin
        do_reset(1'b0);
        t_reports();
        t_i2c();
        t_gpio();
        do_reset(1'b1);
        t_spi();
        t_master_reset();
        summarize();
    end
endmodule // host_port_mode_and_irq_tb
`default_nettype wire
